// ==== hdl/pix_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "raster_params.svh"
module pix_buffer
(
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Fill side
   pix_if.snk         fill,
   // Drain side
   pix_if.src         drain
);
   logic [`COMP_W-1:0] mem_r [2];
   logic               wr_ptr_r;
   logic               rd_ptr_r;
   logic [1:0]         count_r;
   logic               push;
   logic               pop;

   assign fill.ready  = (count_r != 2'h2);
   assign drain.valid = (count_r != 2'h0);
   assign drain.data  = mem_r[rd_ptr_r];
   assign push        = fill.valid && fill.ready;
   assign pop         = drain.valid && drain.ready;

   // ==========================================================
   // Storage
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end
      else if (push)
         mem_r[wr_ptr_r] <= fill.data;
   end

   // ==========================================================
   // Pointers and fill level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= ~wr_ptr_r;
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop)
            count_r <= count_r + 2'h1;
         else if (pop && !push)
            count_r <= count_r - 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/raster_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module raster_counter
#(
   parameter int W = 12
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Control
   input  wire logic          clr,
   input  wire logic          inc,
   input  wire logic [W-1:0]  last,
   // Status
   output logic      [W-1:0]  count,
   output logic               wrap
);
   assign wrap = inc && (count == last);

   // ==========================================================
   // Count with wrap at last
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else if (clr || wrap)
         count <= '0;
      else if (inc)
         count <= count + W'(1);
   end
endmodule
`default_nettype wire

// ==== hdl/raster_timing.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "raster_params.svh"
// Operation
// (R01) Each pixel spans components-per-pixel interface clocks, one component per clock.
// (R02) Each line lasts the programmed line total in interface clocks.
// (R03) Horizontal sync width is programmable in half interface clocks.
// (R04) Vertical sync width is programmable in half interface clocks.
// (R05) Leading horizontal blank lasts the programmed clocks before first active data.
// (R06) Trailing horizontal blank is line total minus lead minus active width.
// (R07) Each frame lasts the programmed line count; vsync spacing equals it.
// (R08) Leading vertical blank lasts the programmed lines before first active line.
// (R09) Trailing vertical blank is frame lines minus lead minus active lines.
// (R10) Pixel data driven only inside both active windows, idle otherwise.
module raster_timing
(
   // APB slave
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [`ADDR_W-1:0]  paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Pixel feed
   input  wire logic                feed_valid,
   input  wire raster_pkg::comp_t   feed_data,
   output logic                     feed_ready,
   // Display panel
   output raster_pkg::comp_t        pix_data,
   output logic                     pix_de,
   output logic                     pix_first,
   output logic                     hsync,
   output logic                     vsync
);
   import raster_pkg::*;

   // ==========================================================
   // Declarations
   logic        enable_r;
   cnt_t        cpp_r;
   cnt_t        line_total_r;
   hs_width_t   hs_width_r;
   cnt_t        lead_clocks_r;
   cnt_t        active_clocks_r;
   cnt_t        frame_lines_r;
   vs_width_t   vs_width_r;
   cnt_t        lead_lines_r;
   cnt_t        active_lines_r;
   logic        underrun_r;
   state_t      state_r;
   logic        run;
   logic        setup;
   logic        wr_access;
   logic        mapped;
   logic [31:0] rd_nxt;
   cnt_t        h_cnt;
   cnt_t        v_cnt;
   cnt_t        comp_cnt;
   logic        h_wrap;
   logic        v_wrap;
   logic [`CNT_W:0] h_end;
   logic [`CNT_W:0] v_end;
   logic        h_act;
   logic        v_act;
   logic        act;
   logic        line_start;
   logic        frame_start;
   logic [`HS_W:0] hs_sum;
   logic [`VS_W:0] vs_sum;
   hs_width_t   hs_full;
   vs_width_t   vs_full;
   hs_width_t   hs_left_r;
   vs_width_t   vs_left_r;
   logic        hs_r;
   logic        vs_r;
   logic        hs_neg_r;
   logic        vs_neg_r;
   comp_t       pix_data_r;
   logic        pix_de_r;
   logic        pix_first_r;
   logic        underrun_set;
   logic        underrun_clr;

   pix_if feed_if ();
   pix_if drain_if ();

   // ==========================================================
   // Feed buffer
   assign feed_if.valid = feed_valid;
   assign feed_if.data  = feed_data;
   assign feed_ready    = feed_if.ready;

   pix_buffer u_buffer
   (
      .clk   (pclk),
      .rst_n (presetn),
      .fill  (feed_if.snk),
      .drain (drain_if.src)
   );

   // ==========================================================
   // APB decode
   assign pready    = 1'b1;
   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite && mapped;

   always_comb
   begin
      mapped = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `OFS_CTRL:          rd_nxt[`CTRL_EN_BIT] = enable_r;
         `OFS_CPP:           rd_nxt[`CNT_W-1:0] = cpp_r;
         `OFS_LINE_TOTAL:    rd_nxt[`CNT_W-1:0] = line_total_r;
         `OFS_HSYNC_WIDTH:   rd_nxt[`HS_W-1:0] = hs_width_r;
         `OFS_LEAD_CLOCKS:   rd_nxt[`CNT_W-1:0] = lead_clocks_r;
         `OFS_ACTIVE_CLOCKS: rd_nxt[`CNT_W-1:0] = active_clocks_r;
         `OFS_FRAME_LINES:   rd_nxt[`CNT_W-1:0] = frame_lines_r;
         `OFS_VSYNC_WIDTH:   rd_nxt[`VS_W-1:0] = vs_width_r;
         `OFS_LEAD_LINES:    rd_nxt[`CNT_W-1:0] = lead_lines_r;
         `OFS_ACTIVE_LINES:  rd_nxt[`CNT_W-1:0] = active_lines_r;
         `OFS_STATUS:
         begin
            rd_nxt[`STAT_RUN_BIT]      = run;
            rd_nxt[`STAT_UNDERRUN_BIT] = underrun_r;
            rd_nxt[`STAT_ACTIVE_BIT]   = act;
         end
         `OFS_POSITION:
         begin
            rd_nxt[`CNT_W-1:0]                  = h_cnt;
            rd_nxt[`POS_V_LSB+`CNT_W-1:`POS_V_LSB] = v_cnt;
         end
         default:            mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // APB answer, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= !mapped;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_r        <= 1'b0;
         cpp_r           <= `RST_CPP;
         line_total_r    <= `RST_LINE_TOTAL;
         hs_width_r      <= `RST_HSYNC_WIDTH;
         lead_clocks_r   <= `RST_LEAD_CLOCKS;
         active_clocks_r <= `RST_ACTIVE_CLOCKS;
         frame_lines_r   <= `RST_FRAME_LINES;
         vs_width_r      <= `RST_VSYNC_WIDTH;
         lead_lines_r    <= `RST_LEAD_LINES;
         active_lines_r  <= `RST_ACTIVE_LINES;
      end
      else if (wr_access)
      begin
         case (paddr)
            `OFS_CTRL:          enable_r <= pwdata[`CTRL_EN_BIT];
            `OFS_CPP:           cpp_r <= pwdata[`CNT_W-1:0];
            `OFS_LINE_TOTAL:    line_total_r <= pwdata[`CNT_W-1:0];
            `OFS_HSYNC_WIDTH:   hs_width_r <= pwdata[`HS_W-1:0];
            `OFS_LEAD_CLOCKS:   lead_clocks_r <= pwdata[`CNT_W-1:0];
            `OFS_ACTIVE_CLOCKS: active_clocks_r <= pwdata[`CNT_W-1:0];
            `OFS_FRAME_LINES:   frame_lines_r <= pwdata[`CNT_W-1:0];
            `OFS_VSYNC_WIDTH:   vs_width_r <= pwdata[`VS_W-1:0];
            `OFS_LEAD_LINES:    lead_lines_r <= pwdata[`CNT_W-1:0];
            `OFS_ACTIVE_LINES:  active_lines_r <= pwdata[`CNT_W-1:0];
            default:            enable_r <= enable_r;
         endcase
      end
   end

   // ==========================================================
   // Run control, stops only at frame end
   assign run = (state_r == ST_RUN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
               if (enable_r)
                  state_r <= ST_RUN;
            ST_RUN:
               if (!enable_r && v_wrap)
                  state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Raster counters
   // (R02) Line length counter
   raster_counter #(.W(`CNT_W)) u_hcnt
   (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (!run),
      .inc   (run),
      .last  (line_total_r - `CNT_W'(1)),
      .count (h_cnt),
      .wrap  (h_wrap)
   );

   // (R07) Frame line counter
   raster_counter #(.W(`CNT_W)) u_vcnt
   (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (!run),
      .inc   (h_wrap),
      .last  (frame_lines_r - `CNT_W'(1)),
      .count (v_cnt),
      .wrap  (v_wrap)
   );

   // (R01) Component within pixel
   raster_counter #(.W(`CNT_W)) u_ccnt
   (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (!act),
      .inc   (act),
      .last  (cpp_r - `CNT_W'(1)),
      .count (comp_cnt),
      .wrap  ()
   );

   // ==========================================================
   // Active windows
   // (R05) (R06) Horizontal window
   assign h_end = {1'b0, lead_clocks_r} + {1'b0, active_clocks_r};
   assign h_act = (h_cnt >= lead_clocks_r) && ({1'b0, h_cnt} < h_end);
   // (R08) (R09) Vertical window
   assign v_end = {1'b0, lead_lines_r} + {1'b0, active_lines_r};
   assign v_act = (v_cnt >= lead_lines_r) && ({1'b0, v_cnt} < v_end);
   assign act   = run && h_act && v_act;

   assign line_start  = run && (h_cnt == '0);
   assign frame_start = line_start && (v_cnt == '0);

   // ==========================================================
   // Pixel output
   assign drain_if.ready = act;
   assign underrun_set   = act && !drain_if.valid;
   assign underrun_clr   = wr_access && (paddr == `OFS_STATUS) && pwdata[`STAT_UNDERRUN_BIT];

   // (R10) Data gated by both windows
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pix_data_r  <= `IDLE_DATA;
         pix_de_r    <= 1'b0;
         pix_first_r <= 1'b0;
      end
      else
      begin
         pix_data_r  <= (act && drain_if.valid) ? drain_if.data : `IDLE_DATA;
         pix_de_r    <= act;
         pix_first_r <= act && (comp_cnt == '0);
      end
   end

   assign pix_data  = pix_data_r;
   assign pix_de    = pix_de_r;
   assign pix_first = pix_first_r;

   // Underrun flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         underrun_r <= 1'b0;
      else
         underrun_r <= underrun_set || (underrun_r && !underrun_clr);
   end

   // ==========================================================
   // Sync pulses, whole clocks rounded up
   assign hs_sum  = {1'b0, hs_width_r} + {`HS_W'(0), 1'b1};
   assign hs_full = hs_sum[`HS_W:1];
   assign vs_sum  = {1'b0, vs_width_r} + {`VS_W'(0), 1'b1};
   assign vs_full = vs_sum[`VS_W:1];

   // (R03) Hsync width counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_r      <= 1'b0;
         hs_left_r <= '0;
      end
      else if (!run)
      begin
         hs_r      <= 1'b0;
         hs_left_r <= '0;
      end
      else if (line_start)
      begin
         hs_r      <= (hs_full != '0);
         hs_left_r <= (hs_full != '0) ? hs_full - `HS_W'(1) : '0;
      end
      else if (hs_left_r != '0)
         hs_left_r <= hs_left_r - `HS_W'(1);
      else
         hs_r <= 1'b0;
   end

   // (R04) (R07) Vsync width counter, once per frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vs_r      <= 1'b0;
         vs_left_r <= '0;
      end
      else if (!run)
      begin
         vs_r      <= 1'b0;
         vs_left_r <= '0;
      end
      else if (frame_start)
      begin
         vs_r      <= (vs_full != '0);
         vs_left_r <= (vs_full != '0) ? vs_full - `VS_W'(1) : '0;
      end
      else if (vs_left_r != '0)
         vs_left_r <= vs_left_r - `VS_W'(1);
      else
         vs_r <= 1'b0;
   end

   // ==========================================================
   // Half-clock trim on falling edge
   always_ff @(negedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hs_neg_r <= 1'b0;
         vs_neg_r <= 1'b0;
      end
      else
      begin
         hs_neg_r <= hs_r;
         vs_neg_r <= vs_r;
      end
   end

   // (R03) (R04) Odd widths lose the first half clock
   assign hsync = hs_width_r[0] ? (hs_r && hs_neg_r) : hs_r;
   assign vsync = vs_width_r[0] ? (vs_r && vs_neg_r) : vs_r;
endmodule
`default_nettype wire

// ==== inc/pix_if.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "raster_params.svh"
interface pix_if;
   logic                valid;
   logic                ready;
   logic [`COMP_W-1:0]  data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== inc/raster_params.svh ====
`ifndef RASTER_PARAMS_SVH
`define RASTER_PARAMS_SVH

// ==========================================================
// Widths
`define CNT_W              12
`define HS_W               13
`define VS_W               20
`define COMP_W             24
`define ADDR_W             8

// ==========================================================
// Register byte offsets
`define OFS_CTRL           8'h00
`define OFS_CPP            8'h04
`define OFS_LINE_TOTAL     8'h08
`define OFS_HSYNC_WIDTH    8'h0C
`define OFS_LEAD_CLOCKS    8'h10
`define OFS_ACTIVE_CLOCKS  8'h14
`define OFS_FRAME_LINES    8'h18
`define OFS_VSYNC_WIDTH    8'h1C
`define OFS_LEAD_LINES     8'h20
`define OFS_ACTIVE_LINES   8'h24
`define OFS_STATUS         8'h28
`define OFS_POSITION       8'h2C

// ==========================================================
// Field positions
`define CTRL_EN_BIT        0
`define STAT_RUN_BIT       0
`define STAT_UNDERRUN_BIT  1
`define STAT_ACTIVE_BIT    2
`define POS_V_LSB          16

// ==========================================================
// Reset values
`define RST_CPP            12'h001
`define RST_LINE_TOTAL     12'h320
`define RST_HSYNC_WIDTH    13'h00C0
`define RST_LEAD_CLOCKS    12'h090
`define RST_ACTIVE_CLOCKS  12'h280
`define RST_FRAME_LINES    12'h20D
`define RST_VSYNC_WIDTH    20'h00C80
`define RST_LEAD_LINES     12'h023
`define RST_ACTIVE_LINES   12'h1E0
`define IDLE_DATA          24'h000000

`endif

// ==== inc/raster_pkg.sv ====
`default_nettype none
`include "raster_params.svh"
package raster_pkg;
   typedef logic [`CNT_W-1:0]  cnt_t;
   typedef logic [`HS_W-1:0]   hs_width_t;
   typedef logic [`VS_W-1:0]   vs_width_t;
   typedef logic [`COMP_W-1:0] comp_t;
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} state_t;
endpackage
`default_nettype wire

// ==== tb/raster_panel.sv ====
`timescale 1ns/10ps
`default_nettype none
module raster_panel
(
   // Clock
   input wire logic              pclk,
   // Panel pins
   input wire raster_pkg::comp_t pix_data,
   input wire logic              pix_de,
   input wire logic              pix_first,
   input wire logic              hsync,
   input wire logic              vsync
);
   import raster_pkg::*;
   realtime t_h = 0.0;
   realtime t_v = 0.0;
   int      hs_h, vs_h, line_h, frm_h, lines, bad;
   int      de_n, de_line, fst_n, fst_line;
   int      act, act_f, pre, pre_f, tail, tail_f;
   logic    hs_p = 1'b0;
   logic    vs_p = 1'b0;
   comp_t   exp_d = 24'h000001;
   // ==========================================
   // Sync timing in half clocks
   // line and hsync
   always @(posedge hsync)
   begin
      line_h = int'(($realtime - t_h) / 5.0);
      t_h = $realtime;
   end
   always @(negedge hsync)
      hs_h = int'(($realtime - t_h) / 5.0);
   always @(posedge vsync)
   begin
      frm_h = int'(($realtime - t_v) / 5.0);
      t_v = $realtime;
   end
   always @(negedge vsync)
      vs_h = int'(($realtime - t_v) / 5.0);
   // ==========================================
   // Line bookkeeping and pixel stream
   always @(posedge pclk)
   begin
      if (hsync && !hs_p)
      begin
         lines++;
         if (de_n > 0)
         begin
            act++;
            de_line = de_n;
            fst_line = fst_n;
         end
         else if (act > 0)
            tail++;
         else
            pre++;
         de_n = 0;
         fst_n = 0;
      end
      if (vsync && !vs_p)
      begin
         act_f = act;
         pre_f = pre;
         tail_f = tail;
         act = 0;
         pre = 0;
         tail = 0;
      end
      if (pix_de)
      begin
         de_n++;
         fst_n += int'(pix_first);
         if (pix_data !== 24'h000000)
         begin
            bad += int'(pix_data !== exp_d);
            exp_d++;
         end
      end
      else if (pix_data !== 24'h000000)
         bad++;
      hs_p = hsync;
      vs_p = vsync;
   end
endmodule
`default_nettype wire

// ==== tb/raster_timing_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module raster_timing_chk
#(
   parameter int CPP = 2,
   parameter int LT  = 20,
   parameter int LB  = 4,
   parameter int AC  = 8,
   parameter int FL  = 6,
   parameter int LL  = 1,
   parameter int AL  = 3
)
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Panel pins
   input wire raster_pkg::comp_t pix_data,
   input wire logic              pix_de,
   input wire logic              pix_first,
   input wire logic              hsync,
   input wire logic              vsync
);
   import raster_pkg::*;
   int   hc;
   int   vl;
   int   fc;
   logic seen;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========================================
   // Position counters
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         hc   <= 0;
         vl   <= 0;
         fc   <= 0;
         seen <= 1'b0;
      end
      else
      begin
         hc   <= $rose(hsync) ? 0 : hc + 1;
         vl   <= $rose(vsync) ? 0 : vl + int'($rose(hsync));
         fc   <= pix_first ? 0 : fc + 1;
         seen <= seen | $rose(hsync);
      end
   // ==========================================
   // Properties
   // pixel grouping
   property p_pix; pix_de |-> pix_first == (!$past(pix_de) || fc == CPP - 1); endproperty
   a_pix: assert property (p_pix) else $error("pixel grouping wrong");
   property p_line; $rose(hsync) && seen |-> hc == LT - 1; endproperty
   a_line: assert property (p_line) else $error("line period wrong");
   property p_vs; $rose(vsync) |-> $rose(hsync); endproperty
   a_vs: assert property (p_vs) else $error("vsync off line start");
   property p_lead; $rose(pix_de) |-> hc == LB - 1; endproperty
   a_lead: assert property (p_lead) else $error("leading blank wrong");
   property p_trail; $fell(pix_de) |-> hc == LB + AC - 1; endproperty
   a_trail: assert property (p_trail) else $error("active width wrong");
   property p_frame; $rose(vsync) && seen |-> vl == FL - 1; endproperty
   a_frame: assert property (p_frame) else $error("frame height wrong");
   property p_vwin; $rose(pix_de) |-> vl >= LL && vl < LL + AL; endproperty
   a_vwin: assert property (p_vwin) else $error("active line outside window");
   property p_idle; !pix_de |-> pix_data == 24'h000000; endproperty
   a_idle: assert property (p_idle) else $error("data not idle");
endmodule
bind raster_timing raster_timing_chk u_chk
(
   .pclk, .presetn, .pix_data, .pix_de, .pix_first, .hsync, .vsync
);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "raster_params.svh"
module testbench;
   import raster_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} row_t;
   localparam int CPP = 2, LT = 20, HW = 5, LB = 4, AC = 8, FL = 6, VW = 41, LL = 1, AL = 3;
   localparam int FRM = FL * LT;
   localparam row_t RST_ROWS [13] = '{
      '{`OFS_CTRL, 32'h00000000, 1'b0},
      '{`OFS_CPP, {20'h00000, `RST_CPP}, 1'b0},
      '{`OFS_LINE_TOTAL, {20'h00000, `RST_LINE_TOTAL}, 1'b0},
      '{`OFS_HSYNC_WIDTH, {19'h00000, `RST_HSYNC_WIDTH}, 1'b0},
      '{`OFS_LEAD_CLOCKS, {20'h00000, `RST_LEAD_CLOCKS}, 1'b0},
      '{`OFS_ACTIVE_CLOCKS, {20'h00000, `RST_ACTIVE_CLOCKS}, 1'b0},
      '{`OFS_FRAME_LINES, {20'h00000, `RST_FRAME_LINES}, 1'b0},
      '{`OFS_VSYNC_WIDTH, {12'h000, `RST_VSYNC_WIDTH}, 1'b0},
      '{`OFS_LEAD_LINES, {20'h00000, `RST_LEAD_LINES}, 1'b0},
      '{`OFS_ACTIVE_LINES, {20'h00000, `RST_ACTIVE_LINES}, 1'b0},
      '{`OFS_STATUS, 32'h00000000, 1'b0},
      '{`OFS_POSITION, 32'h00000000, 1'b0},
      '{8'h30, 32'h00000000, 1'b1}};
   localparam row_t CFG_ROWS [9] = '{
      '{`OFS_CPP, 32'(CPP), 1'b0}, '{`OFS_LINE_TOTAL, 32'(LT), 1'b0},
      '{`OFS_HSYNC_WIDTH, 32'(HW), 1'b0}, '{`OFS_LEAD_CLOCKS, 32'(LB), 1'b0},
      '{`OFS_ACTIVE_CLOCKS, 32'(AC), 1'b0}, '{`OFS_FRAME_LINES, 32'(FL), 1'b0},
      '{`OFS_VSYNC_WIDTH, 32'(VW), 1'b0}, '{`OFS_LEAD_LINES, 32'(LL), 1'b0},
      '{`OFS_ACTIVE_LINES, 32'(AL), 1'b0}};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic        pready, pslverr, er, feed_ready, pix_de, pix_first, hsync, vsync;
   logic        feed_valid = 1'b0, feed_on = 1'b0;
   comp_t       feed_data = 24'h000001, pix_data;
   int          n_fail, checks, cyc, n;
   raster_timing u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .feed_valid, .feed_data, .feed_ready, .pix_data, .pix_de, .pix_first, .hsync, .vsync);
   raster_panel u_panel (.pclk, .pix_data, .pix_de, .pix_first, .hsync, .vsync);
   initial
      forever #5 pclk = ~pclk;
   // ==========================================
   // Feed source holds each word until taken
   always @(posedge pclk)
      if (!feed_valid || feed_ready)
      begin
         feed_valid <= feed_on;
         if (feed_valid)
            feed_data <= feed_data + 24'h000001;
      end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_fail++;
         finish_test();
      end
   end
   // ==========================================
   // Tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      begin
         checks++;
         if (got !== ex)
         begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", nm, ex, got);
         end
      end
   endtask
   task automatic finish_test();
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("idle pins", 32'h00000011, {27'h0000000, pready, pix_de, hsync, vsync, feed_ready});
      foreach (RST_ROWS[i])
      begin
         apb(1'b0, RST_ROWS[i].a, 32'h00000000);
         chk("reset rd", RST_ROWS[i].d, rd);
         chk("slverr", {31'h0, RST_ROWS[i].e}, {31'h0, er});
      end
      feed_on <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("buffer full", 32'h00000000, {31'h0, feed_ready});
      foreach (CFG_ROWS[i])
      begin
         apb(1'b1, CFG_ROWS[i].a, CFG_ROWS[i].d);
         apb(1'b0, CFG_ROWS[i].a, 32'h00000000);
         chk("cfg rd", CFG_ROWS[i].d, rd);
      end
      apb(1'b1, `OFS_CTRL, 32'h00000001);
      repeat (4 * FRM) @(posedge pclk);
      chk("line", 2 * LT, u_panel.line_h);
      chk("hsync", HW, u_panel.hs_h);
      chk("vsync", VW, u_panel.vs_h);
      chk("frame", 2 * FRM, u_panel.frm_h);
      chk("de clocks", AC, u_panel.de_line);
      chk("pixels", AC / CPP, u_panel.fst_line);
      chk("lead lines", LL, u_panel.pre_f);
      chk("act lines", AL, u_panel.act_f);
      chk("tail lines", FL - LL - AL, u_panel.tail_f);
      feed_on <= 1'b0;
      repeat (FRM) @(posedge pclk);
      feed_on <= 1'b1;
      repeat (FRM) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h00000000);
      chk("underrun", 32'h00000003, rd & 32'h00000003);
      apb(1'b1, `OFS_STATUS, 32'h00000002);
      apb(1'b0, `OFS_STATUS, 32'h00000000);
      chk("w1c", 32'h00000001, rd & 32'h00000003);
      apb(1'b1, `OFS_CTRL, 32'h00000000);
      repeat (FRM + 10) @(posedge pclk);
      n = u_panel.lines;
      repeat (2 * LT) @(posedge pclk);
      chk("stopped", n, u_panel.lines);
      apb(1'b0, `OFS_STATUS, 32'h00000000);
      chk("run bit", 32'h00000000, rd & 32'h00000001);
      chk("data", 32'h00000000, u_panel.bad);
      finish_test();
   end
endmodule
`default_nettype wire
